// ### rtl/irq_board_defines.svh
// constants for the serial board interrupt mask and status logic
`ifndef IRQ_BOARD_DEFINES_SVH
`define IRQ_BOARD_DEFINES_SVH
`define PORT_SERIAL_DATA     3'h0
`define PORT_SERIAL_STATUS   3'h1
`define PORT_SERIAL_MODE     3'h2
`define PORT_SERIAL_COMMAND  3'h3
`define PORT_TX_MASK         3'h4
`define PORT_RX_MASK         3'h5
`define PORT_SERIAL_CMD_RD   3'h5
`define MASK_RESET           4'h0
`define NIBBLE_LOW_LSB       0
`define NIBBLE_HIGH_LSB      4
`define UNDRIVEN_BYTE        8'hFF
`endif

// ### rtl/irq_board_pkg.sv
// types for the serial board interrupt mask and status logic
package irq_board_pkg;
    // one bus i/o cycle as seen by the board
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] port;
        logic [7:0] data;
    } io_cycle_t;
    // per relative user source levels
    typedef struct packed {
        logic [3:0] tx;
        logic [3:0] rx;
    } irq_src_t;
endpackage

// ### rtl/irq_source_gen.sv
// per-user source combiner: transmit, receive and optional third condition
`timescale 1ns/1ps
module irq_source_gen
    import irq_board_pkg::*;
(
    // raw conditions per relative user
    input  wire logic [3:0] tx_empty,
    input  wire logic [3:0] rx_ready,
    input  wire logic [3:0] done_change,
    input  wire logic [3:0] done_to_tx,
    input  wire logic [3:0] done_to_rx,
    // combined sources
    output irq_src_t        src
);
    // third condition wire-ored onto either line when chosen
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_user
            assign src.tx[g] = tx_empty[g] | (done_change[g] & done_to_tx[g]);
            assign src.rx[g] = rx_ready[g] | (done_change[g] & done_to_rx[g]);
        end
    endgenerate
endmodule

// ### rtl/serial_board_irq_mask_status.sv
// interrupt mask and status logic of a four-user serial and parallel board
`timescale 1ns/1ps
`include "irq_board_defines.svh"
module serial_board_irq_mask_status
    import irq_board_pkg::*;
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // board configuration
    input  wire logic       UPPER_GROUP_SELECT,
    input  wire logic       GROUP_SELECTED,
    // bus i/o cycle, already decoded to this board
    input  wire logic       IO_WR,
    input  wire logic       IO_RD,
    input  wire logic [2:0] IO_PORT,
    input  wire logic [7:0] IO_WDATA,
    // per-user raw conditions
    input  wire logic [3:0] TX_EMPTY,
    input  wire logic [3:0] RX_READY,
    input  wire logic [3:0] DONE_CHANGE,
    input  wire logic [3:0] DONE_TO_TX,
    input  wire logic [3:0] DONE_TO_RX,
    // read data toward the bus, with per-bit enable (low drives)
    output logic [7:0]      IO_RDATA,
    output logic [7:0]      IO_RDATA_OE_N,
    output logic            IO_RVALID,
    // open-collector interrupt lines, low enable pulls line low
    output logic [3:0]      TRANSMIT_IRQ_OE_N,
    output logic [3:0]      RECEIVE_IRQ_OE_N,
    output logic [3:0]      TRANSMIT_IRQ_O,
    output logic [3:0]      RECEIVE_IRQ_O,
    // serial channel register strobes, one cycle
    output logic [3:0]      SER_WR_STB,
    output logic [3:0]      SER_RD_STB,
    output logic [7:0]      SER_WDATA
);
    io_cycle_t  cyc;            // bundled bus cycle
    irq_src_t   src;            // combined source levels
    logic [3:0] tx_mask_r;      // transmit enables
    logic [3:0] rx_mask_r;      // receive enables
    logic [3:0] wr_nib;         // own nibble of write data
    logic       acc_ok;         // group selected; cycle type decoded separately
    logic       tx_mask_wr;     // write to port 4
    logic       rx_mask_wr;     // write to port 5
    logic       stat_rd;        // read of port 4 or 5
    logic [3:0] stat_nib;       // pending nibble for this read

    assign cyc = '{wr: IO_WR, rd: IO_RD, port: IO_PORT, data: IO_WDATA};

    // source combining for each relative user
    irq_source_gen u_src (
        .tx_empty    (TX_EMPTY),
        .rx_ready    (RX_READY),
        .done_change (DONE_CHANGE),
        .done_to_tx  (DONE_TO_TX),
        .done_to_rx  (DONE_TO_RX),
        .src         (src)
    );

    // decode; the board is only live while its group is selected
    assign acc_ok     = GROUP_SELECTED;
    assign tx_mask_wr = acc_ok & cyc.wr & (cyc.port == `PORT_TX_MASK);
    assign rx_mask_wr = acc_ok & cyc.wr & (cyc.port == `PORT_RX_MASK);
    assign stat_rd    = acc_ok & cyc.rd & ((cyc.port == `PORT_TX_MASK) | (cyc.port == `PORT_RX_MASK));
    // pick the nibble that belongs to this board
    assign wr_nib = UPPER_GROUP_SELECT ? cyc.data[`NIBBLE_HIGH_LSB +: 4]
                                       : cyc.data[`NIBBLE_LOW_LSB +: 4];
    // status is raw source, the mask never touches it
    assign stat_nib = (cyc.port == `PORT_TX_MASK) ? src.tx : src.rx;

    // transmit mask; cleared by reset so nothing reaches the bus
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_mask_r <= `MASK_RESET;
        end else if (tx_mask_wr) begin
            tx_mask_r <= wr_nib;
        end
    end

    // receive mask
    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_mask_r <= `MASK_RESET;
        end else if (rx_mask_wr) begin
            rx_mask_r <= wr_nib;
        end
    end

    // open-collector drive: pull low only when pending and enabled
    // registered so the bus sees a clean level; costs one cycle of latency,
    // which is harmless next to any interrupt response time
    // the data side is tied low: a line is only ever pulled, never pushed
    always_ff @(posedge CLK) begin
        if (RST) begin
            TRANSMIT_IRQ_OE_N <= 4'hF;
            RECEIVE_IRQ_OE_N  <= 4'hF;
            TRANSMIT_IRQ_O    <= 4'h0;
            RECEIVE_IRQ_O     <= 4'h0;
        end else begin
            TRANSMIT_IRQ_OE_N <= ~(src.tx & tx_mask_r);
            RECEIVE_IRQ_OE_N  <= ~(src.rx & rx_mask_r);
            TRANSMIT_IRQ_O    <= 4'h0;
            RECEIVE_IRQ_O     <= 4'h0;
        end
    end

    // read answer, one cycle later, no wait states on status ports
    // two boards may share one group; each drives only its own nibble,
    // so the enables must fall back to all-ones outside an answer
    always_ff @(posedge CLK) begin
        if (RST) begin
            IO_RDATA      <= `UNDRIVEN_BYTE;
            IO_RDATA_OE_N <= 8'hFF;
            IO_RVALID     <= 1'b0;
        end else begin
            IO_RVALID <= stat_rd;
            if (stat_rd) begin
                // own nibble only; the other stays undriven and floats high
                if (UPPER_GROUP_SELECT) begin
                    IO_RDATA      <= {stat_nib, 4'hF};
                    IO_RDATA_OE_N <= 8'h0F;
                end else begin
                    IO_RDATA      <= {4'hF, stat_nib};
                    IO_RDATA_OE_N <= 8'hF0;
                end
            end else begin
                IO_RDATA      <= `UNDRIVEN_BYTE;
                IO_RDATA_OE_N <= 8'hFF;
            end
        end
    end

    // serial register strobes for writes to ports 0-3 and reads of ports 0-2; a port 5 read hits command
    always_ff @(posedge CLK) begin
        if (RST) begin
            SER_WR_STB <= 4'h0;
            SER_RD_STB <= 4'h0;
            SER_WDATA  <= 8'h00;
        end else begin
            SER_WR_STB <= 4'h0;
            SER_RD_STB <= 4'h0;
            SER_WDATA  <= cyc.data;
            if (acc_ok & cyc.wr & ~cyc.port[2]) begin
                SER_WR_STB[cyc.port[1:0]] <= 1'b1;
            end
            if (acc_ok & cyc.rd) begin
                if (cyc.port == `PORT_SERIAL_CMD_RD) begin
                    SER_RD_STB[3] <= 1'b1;
                end else if (cyc.port[2:1] == 2'b00 || cyc.port == `PORT_SERIAL_MODE) begin
                    SER_RD_STB[cyc.port[1:0]] <= 1'b1;
                end
            end
        end
    end

    // checks
    a_reset_mask_off: assert property (@(posedge CLK) RST |=> (tx_mask_r == 4'h0 && rx_mask_r == 4'h0))
        else $error("mask not cleared by reset");
    a_irq_gated: assert property (@(posedge CLK) disable iff (RST)
        1 |=> TRANSMIT_IRQ_OE_N == ~($past(src.tx) & $past(tx_mask_r)))
        else $error("tx line drive wrong");
    a_rx_gated: assert property (@(posedge CLK) disable iff (RST)
        1 |=> RECEIVE_IRQ_OE_N == ~($past(src.rx) & $past(rx_mask_r)))
        else $error("rx line drive wrong");
    a_no_select_no_write: assert property (@(posedge CLK) disable iff (RST)
        (!GROUP_SELECTED) |=> $stable(tx_mask_r) && $stable(rx_mask_r))
        else $error("mask changed while unselected");
    a_mask_write_tx: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_WR && IO_PORT == 3'h4 && !UPPER_GROUP_SELECT) |=> tx_mask_r == $past(IO_WDATA[3:0]))
        else $error("low tx mask write lost");
    a_mask_write_hi: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_WR && IO_PORT == 3'h5 && UPPER_GROUP_SELECT) |=> rx_mask_r == $past(IO_WDATA[7:4]))
        else $error("high rx mask write lost");
    a_status_raw: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_RD && IO_PORT == 3'h4 && !UPPER_GROUP_SELECT) |=> IO_RVALID && IO_RDATA[3:0] == $past(src.tx))
        else $error("tx status not raw source");
    a_other_nibble: assert property (@(posedge CLK) disable iff (RST)
        IO_RVALID |-> (UPPER_GROUP_SELECT ? IO_RDATA_OE_N[3:0] == 4'hF : IO_RDATA_OE_N[7:4] == 4'hF))
        else $error("foreign nibble driven");
    a_write_not_status: assert property (@(posedge CLK) disable iff (RST)
        (IO_WR && !IO_RD) |=> !IO_RVALID)
        else $error("write answered as read");

    // the next four checks cover further nibble and port pairings, all but high board rx status;
    // each one is phrased from the bus side so a wrong decode shows up
    // even when the mask and status paths agree with each other

    // low board, receive mask lands in the low nibble
    a_mask_write_rxlo: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_WR && IO_PORT == 3'h5 && !UPPER_GROUP_SELECT) |=> rx_mask_r == $past(IO_WDATA[3:0]))
        else $error("low rx mask write lost");

    // high board, transmit mask comes from the high nibble
    a_mask_write_txhi: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_WR && IO_PORT == 3'h4 && UPPER_GROUP_SELECT) |=> tx_mask_r == $past(IO_WDATA[7:4]))
        else $error("high tx mask write lost");

    // low board receive status: raw rx levels, only the low nibble driven
    a_status_rx_low: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_RD && IO_PORT == 3'h5 && !UPPER_GROUP_SELECT) |=>
        (IO_RVALID && IO_RDATA[3:0] == $past(src.rx) && IO_RDATA_OE_N == 8'hF0))
        else $error("low rx status wrong");

    // high board transmit status: raw tx levels on the high nibble
    a_status_tx_high: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_RD && IO_PORT == 3'h4 && UPPER_GROUP_SELECT) |=>
        (IO_RVALID && IO_RDATA[7:4] == $past(src.tx) && IO_RDATA_OE_N == 8'h0F))
        else $error("high tx status wrong");

    // status answers come on the very next edge, never stretched
    a_status_no_wait: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_RD && (IO_PORT == 3'h4 || IO_PORT == 3'h5)) |=> IO_RVALID)
        else $error("status answer delayed");

    // a board whose group is not selected stays silent on every port
    a_unselected_quiet: assert property (@(posedge CLK) disable iff (RST)
        (!GROUP_SELECTED) |=> (!IO_RVALID && SER_WR_STB == 4'h0 && SER_RD_STB == 4'h0))
        else $error("unselected board answered");

    // outside an answer nothing is driven onto the data bus
    a_idle_floats: assert property (@(posedge CLK) disable iff (RST)
        (!IO_RVALID) |-> IO_RDATA_OE_N == 8'hFF)
        else $error("bus driven while idle");

    // the foreign nibble carries ones so the pull-ups win anyway
    a_foreign_ones: assert property (@(posedge CLK) disable iff (RST)
        IO_RVALID |-> (UPPER_GROUP_SELECT ? IO_RDATA[3:0] == 4'hF : IO_RDATA[7:4] == 4'hF))
        else $error("foreign nibble not ones");

    // open-collector: the data side of each line never goes high
    a_irq_pins_low: assert property (@(posedge CLK) disable iff (RST)
        (TRANSMIT_IRQ_O == 4'h0 && RECEIVE_IRQ_O == 4'h0))
        else $error("interrupt line driven high");

    // a serial write strobes exactly one channel register
    a_wr_strobe_one: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_WR && !IO_PORT[2]) |=> $onehot(SER_WR_STB))
        else $error("serial write strobe wrong");

    // mask writes must not reach the serial registers
    a_mask_no_strobe: assert property (@(posedge CLK) disable iff (RST)
        (IO_WR && IO_PORT[2]) |=> SER_WR_STB == 4'h0)
        else $error("mask write strobed serial side");

    // a port 5 read also fetches the current command
    a_cmd_rd_strobe: assert property (@(posedge CLK) disable iff (RST)
        (GROUP_SELECTED && IO_RD && IO_PORT == 3'h5) |=> SER_RD_STB == 4'h8)
        else $error("command read strobe missing");

    // every transmit condition, incl. a routed third one, raises the source
    a_tx_source: assert property (@(posedge CLK) disable iff (RST)
        (((TX_EMPTY | (DONE_CHANGE & DONE_TO_TX)) & ~src.tx) == 4'h0))
        else $error("tx source missing");

    // every receive condition, incl. a routed third one, raises the source
    a_rx_source: assert property (@(posedge CLK) disable iff (RST)
        (((RX_READY | (DONE_CHANGE & DONE_TO_RX)) & ~src.rx) == 4'h0))
        else $error("rx source missing");

    // main scenarios worth seeing at least once
    c_tx_write: cover property (@(posedge CLK) tx_mask_wr);
    c_rx_read: cover property (@(posedge CLK) stat_rd && cyc.port == 3'h5);
    c_irq_out: cover property (@(posedge CLK) TRANSMIT_IRQ_OE_N != 4'hF);
    c_upper_read: cover property (@(posedge CLK) stat_rd && UPPER_GROUP_SELECT);
    c_cmd_strobe: cover property (@(posedge CLK) SER_RD_STB[3]);
endmodule

// ### sim/channel_model.sv
// far-side channel model: per-user condition levels behind the board
`timescale 1ns/1ps
module channel_model
    import irq_board_pkg::*;
(
    // clock
    input  wire logic     CLK,
    // levels the bench asks for, and levels presented
    input  wire irq_src_t want,
    output irq_src_t      level
);
    // one cycle of lag, as a real channel settles after its own clock
    always_ff @(posedge CLK) begin
        level <= want;
    end
endmodule

// ### sim/serial_board_irq_mask_status_test.sv
// self-checking bench for the interrupt mask and status block
`timescale 1ns/1ps
module serial_board_irq_mask_status_test
    import irq_board_pkg::*;
;
    logic       clk, rst, upper, sel;           // clock, reset, configuration
    io_cycle_t  cyc;                            // bus cycle toward the board
    irq_src_t   want, lvl;                      // asked and presented levels
    logic [3:0] done, to_tx, to_rx, txs, rxs;   // third condition and sums
    logic [3:0] tmask, rmask, tx_oe_n, rx_oe_n, wr_stb, rd_stb;
    logic [7:0] rdata, rdata_oe_n, wdata;
    logic       rvalid;
    logic [3:0] tx_o, rx_o;                     // data side of the irq lines
    logic [7:0] exp_q[$];                       // expected read answers
    int         fail_count, checks_done, seed;
    // undriven bits read as ones on the bus
    wire  [7:0] bus = (rdata & ~rdata_oe_n) | rdata_oe_n;
    channel_model i_channel_model (.CLK(clk), .want(want), .level(lvl));
    serial_board_irq_mask_status i_serial_board_irq_mask_status (
        .CLK(clk), .RST(rst), .UPPER_GROUP_SELECT(upper), .GROUP_SELECTED(sel),
        .IO_WR(cyc.wr), .IO_RD(cyc.rd), .IO_PORT(cyc.port), .IO_WDATA(cyc.data),
        .TX_EMPTY(lvl.tx), .RX_READY(lvl.rx), .DONE_CHANGE(done), .DONE_TO_TX(to_tx),
        .DONE_TO_RX(to_rx), .IO_RDATA(rdata), .IO_RDATA_OE_N(rdata_oe_n), .IO_RVALID(rvalid),
        .TRANSMIT_IRQ_OE_N(tx_oe_n), .RECEIVE_IRQ_OE_N(rx_oe_n), .TRANSMIT_IRQ_O(tx_o),
        .RECEIVE_IRQ_O(rx_o), .SER_WR_STB(wr_stb), .SER_RD_STB(rd_stb), .SER_WDATA(wdata));
    // compare and count
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle held across one sampling edge, then a gap
    task automatic io(input logic w, input logic r, input logic [2:0] p, input logic [7:0] d);
        cyc = '{wr: w, rd: r, port: p, data: d};
        @(negedge clk);
        cyc = '0;
        @(negedge clk);
    endtask
    task automatic test_done;
        if (exp_q.size() != 0) fail_count++;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        fail_count++;
        test_done;
    end
    // answer watcher: an answer with no note pending is a mismatch
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) cmp(bus, ~bus);
            else cmp(bus, exp_q.pop_front());
        end
    end
    initial begin
        seed = 53;
        {rst, sel, upper, cyc, want, done, to_tx, to_rx} = {1'b1, 1'b1, 1'b0, 13'h0, 20'h0};
        fail_count = 0;
        checks_done = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        cmp({tx_oe_n, rx_oe_n}, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            upper = k[0];
            {want, done, to_tx, to_rx} = 20'($random(seed));
            {tmask, rmask} = 8'($random(seed));
            repeat (3) @(negedge clk);
            txs = want.tx | (done & to_tx);
            rxs = want.rx | (done & to_rx);
            exp_q.push_back(upper ? {txs, 4'hF} : {4'hF, txs});
            io(1'b0, 1'b1, 3'h4, 8'h00);
            exp_q.push_back(upper ? {rxs, 4'hF} : {4'hF, rxs});
            io(1'b0, 1'b1, 3'h5, 8'h00);
            io(1'b1, 1'b0, 3'h4, upper ? {tmask, ~tmask} : {~tmask, tmask});
            io(1'b1, 1'b0, 3'h5, upper ? {rmask, ~rmask} : {~rmask, rmask});
            sel = 1'b0;
            io(1'b1, 1'b0, 3'h4, 8'hFF);
            io(1'b0, 1'b1, 3'h5, 8'h00);
            sel = 1'b1;
            repeat (2) @(negedge clk);
            cmp({tx_oe_n, rx_oe_n}, {~(txs & tmask), ~(rxs & rmask)});
            $display("test %0d finished", k);
        end
        // reset in mid-run with every mask and every source up
        want = 8'hFF;
        io(1'b1, 1'b0, 3'h4, 8'hFF);
        io(1'b1, 1'b0, 3'h5, 8'hFF);
        cmp({tx_oe_n, rx_oe_n}, 8'h00);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        cmp({tx_oe_n, rx_oe_n}, 8'hFF);
        cmp({tx_o, rx_o}, 8'h00);
        $display("test reset finished");
        // serial channel register strobes, back to back
        for (int p = 0; p < 4; p++) begin
            cyc = '{wr: 1'b1, rd: 1'b0, port: p[2:0], data: 8'hA5 ^ 8'(p)};
            @(negedge clk);
            cmp({wr_stb, 4'h0}, {4'h1 << p, 4'h0});
            cmp(wdata, 8'hA5 ^ 8'(p));
            cyc = '{wr: 1'b0, rd: 1'b1, port: (p == 3) ? 3'h5 : p[2:0], data: 8'h00};
            if (p == 3) exp_q.push_back(upper ? {want.rx | (done & to_rx), 4'hF}
                                              : {4'hF, want.rx | (done & to_rx)});
            @(negedge clk);
            cmp({rd_stb, 4'h0}, {4'h1 << p, 4'h0});
            cyc = '0;
            @(negedge clk);
        end
        $display("test strobes finished");
        test_done;
    end
endmodule
